/* core/cth_clock_timer.v */
`timescale 1ns/100ps
`include "cth_consts.vh"

// Overview of operation
// RULE1: crystal-derived 256 Hz tick drives an 8-bit binary up-counter, 128 Hz to 1 Hz.
// RULE2: counter bits 0-3 read at low nibble register, bits 4-7 at high nibble.
// RULE3: high nibble advances only by carry out of the low nibble.
// RULE4: low nibble read holds high-nibble carries until high read or hold timeout.
// RULE5: software reads low nibble first; high read alone starts no hold.
// RULE6: falling edges of 32, 16, 2 and 1 Hz stages each set an event flag.
// RULE7: flags set regardless of enables; enables gate only the interrupt request.
// RULE8: enable register holds four read/write bits, 1 enables, reset to zero.
// RULE9: flag register is read-only, same bit order, clears after read, resets zero.
// RULE10: software changes enables only while processor interrupts are disabled.
// RULE11: restart bit 0 resets timer and watchdog; bit 1 resets watchdog only.
// RULE12: restart register reads zero; counter registers are read-only.
// RULE13: system reset clears the counter to zero.
// RULE14: entering sleep resets the clock timer.
// RULE15: interrupt request stays high while any enabled flag is set.
module cth_clock_timer #(
	parameter HOLD_CYCLES = `CTH_HOLD_US * `CTH_CLK_MHZ
) (
	// clock and reset
	input  wire        aclk,
	input  wire        aresetn,
	// write address channel
	input  wire [9:0]  s_axi_awaddr,
	input  wire        s_axi_awvalid,
	output reg         s_axi_awready,
	// write data channel
	input  wire [31:0] s_axi_wdata,
	input  wire [3:0]  s_axi_wstrb,
	input  wire        s_axi_wvalid,
	output reg         s_axi_wready,
	// write response channel
	output reg  [1:0]  s_axi_bresp,
	output reg         s_axi_bvalid,
	input  wire        s_axi_bready,
	// read address channel
	input  wire [9:0]  s_axi_araddr,
	input  wire        s_axi_arvalid,
	output reg         s_axi_arready,
	// read data channel
	output reg  [31:0] s_axi_rdata,
	output reg  [1:0]  s_axi_rresp,
	output reg         s_axi_rvalid,
	input  wire        s_axi_rready,
	// crystal and processor
	input  wire        crystal_clock_input,
	input  wire        sleep_instruction,
	// outputs to the system
	output reg         timer_irq,
	output reg         watchdog_restart_strobe
);

	function [7:0] cth_index;
		input [9:0] addr;
		begin
			cth_index = addr[9:2];
		end
	endfunction

	function cth_mapped;
		input [7:0] idx;
		begin
			case (idx)
				`CTH_IDX_RESTART,
				`CTH_IDX_COUNT_LO,
				`CTH_IDX_COUNT_HI,
				`CTH_IDX_ENABLES,
				`CTH_IDX_FLAGS,
				`CTH_IDX_STATUS,
				`CTH_IDX_HOLD: cth_mapped = 1'b1;
				default: cth_mapped = 1'b0;
			endcase
		end
	endfunction

	// crystal synchroniser and prescaler
	reg        xtal_meta;
	reg        xtal_sync;
	reg        xtal_prev;
	reg  [6:0] xtal_div;
	wire       xtal_rise;
	wire       tick_256hz;

	// counter and hold state
	reg  [3:0] count_lo;
	reg  [3:0] count_hi;
	reg        hold_active;
	reg        carry_pending;
	reg  [13:0] hold_cnt;
	reg  [3:0] next_lo;
	reg  [3:0] next_hi;
	reg        next_hold_active;
	reg        next_carry_pending;
	reg  [13:0] next_hold_cnt;

	// registers and events
	reg  [3:0] enables;
	reg  [3:0] flags;
	wire [3:0] next_flags;
	wire [3:0] flag_set;
	reg  [3:0] flag_clr;
	wire [7:0] fall;

	// bus state
	reg        aw_full;
	reg        w_full;
	reg  [7:0] aw_idx;
	reg  [31:0] w_data;
	reg  [3:0] w_strb;
	wire       do_write;
	wire       rd_take;
	wire [7:0] rd_idx;
	wire       wr_lo_byte;
	wire       restart_timer;
	wire       restart_wdog;
	wire       rd_lo;
	wire       rd_hi;
	wire       hold_timeout;
	wire       carry;
	wire       wr_restart;
	wire       wr_enables;
	wire       wr_status;
	wire       rd_flags;

	// the first stage feeds only the second; edges use the clean copy
	always @(posedge aclk) begin
		if (!aresetn) begin
			xtal_meta <= 1'b0;
			xtal_sync <= 1'b0;
			xtal_prev <= 1'b0;
		end else begin
			xtal_meta <= crystal_clock_input;
			xtal_sync <= xtal_meta;
			xtal_prev <= xtal_sync;
		end
	end

	assign xtal_rise  = xtal_sync & ~xtal_prev;
	assign tick_256hz = xtal_rise && (xtal_div == `CTH_XTAL_DIV_LAST);

	assign do_write = aw_full & w_full & ~s_axi_bvalid;
	assign rd_take  = s_axi_arvalid & s_axi_arready;
	assign rd_idx   = cth_index(s_axi_araddr);
	assign wr_lo_byte = do_write & w_strb[0];

	assign restart_timer = (wr_restart && w_data[`CTH_RST_TIMER_BIT]) ||
		sleep_instruction; // RULE11 RULE14
	assign restart_wdog = wr_restart &&
		(w_data[`CTH_RST_WDOG_BIT] || w_data[`CTH_RST_TIMER_BIT]); // RULE11

	assign rd_lo = rd_take && rd_idx == `CTH_IDX_COUNT_LO;
	assign rd_hi = rd_take && rd_idx == `CTH_IDX_COUNT_HI;
	assign hold_timeout = hold_active &&
		(hold_cnt == HOLD_CYCLES[13:0] - 14'h0001);
	assign carry = tick_256hz && (count_lo == 4'hF);
	assign wr_restart = wr_lo_byte && aw_idx == `CTH_IDX_RESTART;
	assign wr_enables = wr_lo_byte && aw_idx == `CTH_IDX_ENABLES;
	assign wr_status  = wr_lo_byte && aw_idx == `CTH_IDX_STATUS;
	assign rd_flags   = rd_take && rd_idx == `CTH_IDX_FLAGS;

	// prescaler restarts with the counter so the first tick is a full period
	always @(posedge aclk) begin
		if (!aresetn || restart_timer)
			xtal_div <= 7'h00;
		else if (xtal_rise)
			xtal_div <= xtal_div + 7'h01;
	end

	// a carry can arrive only every 62 ms, far longer than a hold,
	// so one pending bit is enough to keep the count continuous
	always @* begin
		next_lo            = count_lo;
		next_hi            = count_hi;
		next_hold_active   = hold_active;
		next_carry_pending = carry_pending;
		next_hold_cnt      = hold_cnt;
		if (tick_256hz)
			next_lo = count_lo + 4'h1; // RULE1
		if (hold_active && !(rd_hi || hold_timeout)) begin
			next_carry_pending = carry_pending | carry; // RULE4
			next_hold_cnt      = hold_cnt + 14'h0001;
		end else begin
			next_hi = count_hi + {3'b000, carry} +
				{3'b000, carry_pending}; // RULE3
			next_carry_pending = 1'b0;
			next_hold_active   = 1'b0; // RULE4
			next_hold_cnt      = 14'h0000;
		end
		// a carry on the edge of a low read is held and an older one
		// applied, so each low read pairs with the high nibble after it
		if (rd_lo) begin
			next_hi            = count_hi + {3'b000, carry_pending};
			next_carry_pending = carry; // RULE4
			next_hold_active = 1'b1; // RULE4 RULE5
			next_hold_cnt    = 14'h0000;
		end
		if (restart_timer) begin
			{next_hi, next_lo} = `CTH_COUNT_RST;
			next_hold_active   = 1'b0;
			next_carry_pending = 1'b0;
			next_hold_cnt      = 14'h0000;
		end
	end

	always @(posedge aclk) begin
		if (!aresetn) begin
			{count_hi, count_lo} <= `CTH_COUNT_RST; // RULE13
			hold_active   <= 1'b0;
			carry_pending <= 1'b0;
			hold_cnt      <= 14'h0000;
		end else begin
			count_lo      <= next_lo;
			count_hi      <= next_hi;
			hold_active   <= next_hold_active;
			carry_pending <= next_carry_pending;
			hold_cnt      <= next_hold_cnt;
		end
	end

	// a restart drops the stages to zero and may raise flags itself
	assign fall = {count_hi, count_lo} & ~{next_hi, next_lo};
	assign flag_set = {fall[`CTH_STAGE_1HZ], fall[`CTH_STAGE_2HZ],
		fall[`CTH_STAGE_16HZ], fall[`CTH_STAGE_32HZ]}; // RULE6 RULE7

	always @* begin
		flag_clr = 4'h0;
		if (rd_flags)
			flag_clr = flags; // RULE9
		if (wr_status)
			flag_clr = flag_clr | w_data[3:0];
	end

	genvar g;
	generate
		for (g = 0; g < 4; g = g + 1) begin : g_flag
			// a new edge wins over a clear in the same cycle
			assign next_flags[g] = flag_set[g] |
				(flags[g] & ~flag_clr[g]); // RULE6
		end
	endgenerate

	always @(posedge aclk) begin
		if (!aresetn) begin
			flags     <= `CTH_FLAGS_RST; // RULE9
			enables   <= `CTH_ENABLES_RST; // RULE8
			timer_irq <= 1'b0;
		end else begin
			flags <= next_flags;
			if (wr_enables)
				enables <= w_data[3:0]; // RULE8 RULE10
			timer_irq <= |(next_flags & enables); // RULE15 RULE7
		end
	end

	always @(posedge aclk) begin
		if (!aresetn)
			watchdog_restart_strobe <= 1'b0;
		else
			watchdog_restart_strobe <= restart_wdog; // RULE11
	end

	// write side: address and data may come in either order
	always @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_awready <= 1'b1;
			s_axi_wready  <= 1'b1;
			s_axi_bvalid  <= 1'b0;
			s_axi_bresp   <= `CTH_RESP_OKAY;
			aw_full       <= 1'b0;
			w_full        <= 1'b0;
			aw_idx        <= 8'h00;
			w_data        <= 32'h00000000;
			w_strb        <= 4'h0;
		end else begin
			if (s_axi_awvalid && s_axi_awready) begin
				aw_full       <= 1'b1;
				aw_idx        <= cth_index(s_axi_awaddr);
				s_axi_awready <= 1'b0;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				w_full       <= 1'b1;
				w_data       <= s_axi_wdata;
				w_strb       <= s_axi_wstrb;
				s_axi_wready <= 1'b0;
			end
			if (do_write) begin
				aw_full      <= 1'b0;
				w_full       <= 1'b0;
				s_axi_bvalid <= 1'b1;
				// writes to read-only places are dropped quietly
				s_axi_bresp  <= cth_mapped(aw_idx) ?
					`CTH_RESP_OKAY : `CTH_RESP_SLVERR; // RULE12
			end
			if (s_axi_bvalid && s_axi_bready) begin
				s_axi_bvalid  <= 1'b0;
				s_axi_awready <= 1'b1;
				s_axi_wready  <= 1'b1;
			end
		end
	end

	// read side: one read at a time, data registered at acceptance
	always @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_arready <= 1'b1;
			s_axi_rvalid  <= 1'b0;
			s_axi_rdata   <= 32'h00000000;
			s_axi_rresp   <= `CTH_RESP_OKAY;
		end else begin
			if (rd_take) begin
				s_axi_arready <= 1'b0;
				s_axi_rvalid  <= 1'b1;
				s_axi_rresp   <= cth_mapped(rd_idx) ?
					`CTH_RESP_OKAY : `CTH_RESP_SLVERR;
				case (rd_idx)
					`CTH_IDX_COUNT_LO:
						s_axi_rdata <= {28'h0000000, count_lo}; // RULE2
					`CTH_IDX_COUNT_HI:
						s_axi_rdata <= {28'h0000000, count_hi}; // RULE2
					`CTH_IDX_ENABLES:
						s_axi_rdata <= {28'h0000000, enables}; // RULE8
					`CTH_IDX_FLAGS,
					`CTH_IDX_STATUS:
						s_axi_rdata <= {28'h0000000, flags}; // RULE9
					`CTH_IDX_HOLD:
						s_axi_rdata <= {30'h00000000, carry_pending,
							hold_active};
					default:
						s_axi_rdata <= 32'h00000000; // RULE12
				endcase
			end
			if (s_axi_rvalid && s_axi_rready) begin
				s_axi_rvalid  <= 1'b0;
				s_axi_arready <= 1'b1;
			end
		end
	end

endmodule // cth_clock_timer

/* core/cth_consts.vh */
`ifndef CTH_CONSTS_VH
`define CTH_CONSTS_VH

// register indices, byte address is four times the index
`define CTH_IDX_RESTART   8'hD4
`define CTH_IDX_COUNT_LO  8'hD5
`define CTH_IDX_COUNT_HI  8'hD6
`define CTH_IDX_ENABLES   8'hF1
`define CTH_IDX_FLAGS     8'hF5
`define CTH_IDX_STATUS    8'hF6
`define CTH_IDX_HOLD      8'hF7

// restart strobe fields
`define CTH_RST_TIMER_BIT 0
`define CTH_RST_WDOG_BIT  1

// hold status fields
`define CTH_HOLD_ACT_BIT  0
`define CTH_HOLD_PEND_BIT 1

// counter stage positions that raise events
`define CTH_STAGE_32HZ    2
`define CTH_STAGE_16HZ    3
`define CTH_STAGE_2HZ     6
`define CTH_STAGE_1HZ     7

// reset values
`define CTH_COUNT_RST     8'h00
`define CTH_ENABLES_RST   4'h0
`define CTH_FLAGS_RST     4'h0

// crystal edges per 256 Hz tick, minus one
`define CTH_XTAL_DIV_LAST 7'h7F

// hold interval in microseconds and clock rate in MHz
`define CTH_HOLD_US       1000
`define CTH_CLK_MHZ       10

// bus answers
`define CTH_RESP_OKAY     2'h0
`define CTH_RESP_SLVERR   2'h2

`endif

/* testbench/cth_clock_timer_sva.sv */
`timescale 1ns/100ps
module cth_chk (
	// clock and reset
	input logic        aclk,
	input logic        aresetn,
	// write side
	input logic [9:0]  s_axi_awaddr,
	input logic        s_axi_awvalid,
	input logic        s_axi_awready,
	input logic [31:0] s_axi_wdata,
	input logic [3:0]  s_axi_wstrb,
	input logic        s_axi_wvalid,
	input logic        s_axi_wready,
	input logic        s_axi_bvalid,
	// read side
	input logic [9:0]  s_axi_araddr,
	input logic        s_axi_arvalid,
	input logic        s_axi_arready,
	input logic [31:0] s_axi_rdata,
	input logic [1:0]  s_axi_rresp,
	input logic        s_axi_rvalid,
	// system outputs
	input logic        timer_irq,
	input logic        watchdog_restart_strobe
);
	default clocking @(posedge aclk); endclocking
	default disable iff (!aresetn);
	sequence wr_hs;
		s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
	endsequence
	sequence rd_hs;
		s_axi_arvalid && s_axi_arready;
	endsequence
	reset_idle_a: assert property (
		$rose(aresetn) |-> s_axi_awready && s_axi_arready && !timer_irq)
		else $error("bus or irq not idle after reset");
	wr_answer_a: assert property (wr_hs |=> ##1 s_axi_bvalid)
		else $error("write response late");
	aw_busy_a: assert property (wr_hs |=> !s_axi_awready [*2])
		else $error("write address taken while busy");
	rd_answer_a: assert property (rd_hs |=> s_axi_rvalid)
		else $error("read data late");
	upper_zero_a: assert property (
		rd_hs |=> s_axi_rdata[31:4] == 28'h0)
		else $error("upper read bits not zero");
	restart_zero_a: assert property (
		rd_hs ##0 s_axi_araddr == 10'h350 |=> s_axi_rdata == 32'h0)
		else $error("restart register reads nonzero");
	unmapped_rd_a: assert property (
		rd_hs ##0 s_axi_araddr == 10'h000 |=> s_axi_rresp == 2'h2)
		else $error("unmapped read not refused");
	wdog_pulse_a: assert property (
		wr_hs ##0 s_axi_awaddr == 10'h350 && s_axi_wstrb[0] &&
		s_axi_wdata[1:0] != 2'h0 |=> ##[1:2] watchdog_restart_strobe)
		else $error("watchdog strobe missing");
	wdog_single_a: assert property (
		watchdog_restart_strobe |=> !watchdog_restart_strobe)
		else $error("watchdog strobe too long");
endmodule // cth_chk

bind cth_clock_timer cth_chk chk (.*);

/* testbench/testbench.sv */
`timescale 1ns/100ps
module testbench;
	logic        aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid;
	logic        s_axi_wready, s_axi_bvalid, s_axi_bready, s_axi_arvalid;
	logic        s_axi_arready, s_axi_rvalid, s_axi_rready, timer_irq;
	logic        watchdog_restart_strobe, crystal_clock_input;
	logic        sleep_instruction;
	logic [9:0]  s_axi_awaddr, s_axi_araddr;
	logic [31:0] s_axi_wdata, s_axi_rdata, d;
	logic [3:0]  s_axi_wstrb;
	logic [1:0]  s_axi_bresp, s_axi_rresp, rs;
	int          err_count, comparisons, cyc;

	cth_clock_timer #(.HOLD_CYCLES(1000)) dut (.*);

	initial begin
		aclk = 1'b0;
		forever #50 aclk = ~aclk;
	end

	// crystal at half the bus clock: one tick per 256 cycles, so a wrap fits
	always @(posedge aclk) begin
		crystal_clock_input <= ~crystal_clock_input;
		cyc <= cyc + 1;
		if (cyc == 90000) begin
			err_count++;
			end_sim;
		end
	end

	task end_sim;
		if (err_count == 0 && comparisons > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask

	task chk(input logic [31:0] got, input logic [31:0] exp);
		comparisons++;
		if (got !== exp) begin
			$display("mismatch at %0t got %h exp %h", $time, got, exp);
			err_count++;
		end
	endtask

	task wt(input int n);
		repeat (n) @(posedge aclk);
	endtask

	task wr(input logic [7:0] idx, input logic [3:0] v);
		@(posedge aclk);
		s_axi_awaddr <= {idx, 2'h0};
		s_axi_wdata <= {28'h0, v};
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		do begin
			@(posedge aclk);
			if (s_axi_awready) s_axi_awvalid <= 1'b0;
			if (s_axi_wready) s_axi_wvalid <= 1'b0;
		end while (!s_axi_bvalid);
		rs = s_axi_bresp;
		s_axi_bready <= 1'b0;
	endtask

	task rd(input logic [7:0] idx);
		@(posedge aclk);
		s_axi_araddr <= {idx, 2'h0};
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		do begin
			@(posedge aclk);
			if (s_axi_arready) s_axi_arvalid <= 1'b0;
		end while (!s_axi_rvalid);
		d = s_axi_rdata;
		rs = s_axi_rresp;
		s_axi_rready <= 1'b0;
	endtask

	task restart;
		wr(8'hD4, 4'h1); chk(watchdog_restart_strobe, 1'b1);
		rd(8'hF5);
	endtask

	task t_reset;
		rd(8'hF1); chk(d, 32'h0);
		rd(8'hF5); chk(d, 32'h0);
		rd(8'hD5); chk(d, 32'h0);
		rd(8'hD6); chk(d, 32'h0);
		wr(8'hF1, 4'hF); rd(8'hF1); chk(d, 32'hF);
		wr(8'hF1, 4'h0);
		wr(8'hD4, 4'hC); chk(watchdog_restart_strobe, 1'b0);
		chk(rs, 2'h0);
		rd(8'hD4); chk(d, 32'h0);
		rd(8'h00); chk(rs, 2'h2);
		wr(8'h00, 4'h1); chk(rs, 2'h2);
	endtask

	task t_hold;
		restart;
		wt(3940); rd(8'hD5); chk(d, 32'hF);
		rd(8'hF7); chk(d, 32'h1);
		wt(300); rd(8'hF7); chk(d, 32'h3);
		rd(8'hD6); chk(d, 32'h0);
		rd(8'hD5); chk(d, 32'h0);
		rd(8'hD6); chk(d, 32'h1);
		chk(timer_irq, 1'b0);
		rd(8'hF5); chk(d, 32'h3);
		rd(8'hF5); chk(d, 32'h0);
		// lock the count at 0x1F, then let the hold run out
		wt(3740); rd(8'hD5); chk(d, 32'hF);
		wt(1300); rd(8'hD6); chk(d, 32'h2);
	endtask

	task t_irq;
		wr(8'hF1, 4'h1);
		wt(2100); chk(timer_irq, 1'b1);
		rd(8'hF6); chk(d[1:0], 2'h3);
		wr(8'hF6, 4'h2); chk(timer_irq, 1'b1);
		rd(8'hF5); chk(d[0], 1'b1);
		chk(d[1], 1'b0);
		wt(2); chk(timer_irq, 1'b0);
		wr(8'hF1, 4'h0);
	endtask

	task t_sleep;
		wr(8'hD4, 4'h2); chk(watchdog_restart_strobe, 1'b1);
		@(posedge aclk) sleep_instruction <= 1'b1;
		@(posedge aclk) sleep_instruction <= 1'b0;
		rd(8'hD5); chk(d, 32'h0);
		rd(8'hD6); chk(d, 32'h0);
	endtask

	task t_wrap;
		restart;
		wt(65664); rd(8'hF5); chk(d, 32'hF);
	endtask

	initial begin
		{aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_arvalid} = 4'h0;
		{s_axi_bready, s_axi_rready, sleep_instruction} = 3'h0;
		{s_axi_awaddr, s_axi_araddr, s_axi_wdata} = 52'h0;
		s_axi_wstrb = 4'hF;
		crystal_clock_input = 1'b0;
		{err_count, comparisons, cyc} = 0;
		wt(12);
		aresetn <= 1'b1;
		t_reset;
		t_hold;
		t_irq;
		t_sleep;
		t_wrap;
		end_sim;
	end
endmodule // testbench
